// *** core/wtc_defines.svh ***
`ifndef WTC_DEFINES_SVH
`define WTC_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define WTC_ADDR_W 12
`define WTC_CTRL_OFF 12'hc00
`define WTC_CTRL_CLR_OFF 12'hc04
`define WTC_CTRL_SET_OFF 12'hc08
`define WTC_CTRL_INV_OFF 12'hc0c
`define WTC_STAT_OFF 12'hc10
`define WTC_MASK_OFF 12'hc14
`define WTC_COUNT_OFF 12'hc18

// ****************************************
// Control fields
// ****************************************
`define WTC_KEY 16'h5743
`define WTC_KEY_STRB 4'hc
`define WTC_CTRL_WMASK 32'h00008001
`define WTC_CTRL_RESET 32'h00000000
`define WTC_ON_BIT 15
`define WTC_WINEN_BIT 0
`define WTC_PS_W 5

// ****************************************
// Status and mask fields
// ****************************************
`define WTC_EV_W 4
`define WTC_EV_EXPIRE 0
`define WTC_EV_FAULT 1
`define WTC_EV_WAKE 2
`define WTC_EV_BADKEY 3
`define WTC_EV_RESET 4'h0

// ****************************************
// Bus answers
// ****************************************
`define WTC_RESP_OKAY 2'h0
`define WTC_RESP_SLVERR 2'h2

`endif

// *** core/wtc_pkg.sv ***
package wtc_pkg;
    typedef logic [1:0] wtc_resp_type;
    typedef logic [4:0] wtc_ps_type;
    typedef enum logic [0:0] {
        WTC_RD_IDLE = 1'b0,
        WTC_RD_DATA = 1'b1
    } wtc_rd_state_type;
endpackage

// *** core/wtc_tick_counter.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wtc_defines.svh"

module wtc_tick_counter (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic run,
    input wire logic clear,
    input wire wtc_pkg::wtc_ps_type postscale,
    output var logic expire,
    output var logic window_open,
    output var logic [31:0] count
);
    import wtc_pkg::*;

    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic expire_reg;
    logic expire_next;
    logic [31:0] terminal;
    logic [31:0] open_thr;

    // ****************************************
    // Postscaled time-out
    // ****************************************
    // Time-out is two to the postscale power of oscillator ticks
    assign terminal = (32'h1 << postscale) - 32'h1;
    // Window opens for the last quarter of the period
    assign open_thr = terminal - (terminal >> 2);

    always_comb begin
        count_next = count_reg;
        expire_next = 1'b0;
        if (!run || clear) begin
            count_next = 32'h0;
        end else if (tick) begin
            if (count_reg >= terminal) begin
                count_next = 32'h0;
                expire_next = 1'b1;
            end else begin
                count_next = count_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= 32'h0;
            expire_reg <= 1'b0;
        end else if (clk_en) begin
            count_reg <= count_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;
    assign window_open = count_reg >= open_thr;
    assign count = count_reg;
endmodule // wtc_tick_counter

`default_nettype wire

// *** core/wtc_watchdog_timer_control.sv ***
// Contract
// - Counter advances only on edges of the low-power oscillator input.
// - Expiry without a timely clear requests a device reset.
// - Postscaler sets the time-out as a power-of-two tick count.
// - Expiry during Sleep or Idle wakes the device instead.
// - Only a halfword write of the key restarts the time-out.
// - Enable bit 15 starts or stops the watchdog; resets to zero.
// - Software enable counts only when the fuse enable is zero.
// - Read-only bits 12-8 show the run-mode configured postscale.
// - Read-only bits 5-1 show the sleep-mode configured postscale.
// - Bit 0 selects windowed operation; resets to zero.
// - Clear, set and invert aliases at plus 0x4, 0x8, 0xC.
// - Bits 14-13 and 7-6 read zero and ignore writes.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "wtc_defines.svh"

module wtc_watchdog_timer_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic low_power_rc_oscillator_clk_pin,
    input wire logic fuse_watchdog_enable,
    input wire wtc_pkg::wtc_ps_type cfg_run_postscale,
    input wire wtc_pkg::wtc_ps_type cfg_sleep_postscale,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    output var wtc_pkg::wtc_resp_type s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    output var logic [31:0] s_axi_rdata,
    output var wtc_pkg::wtc_resp_type s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var logic device_reset_req,
    output var logic wake_req,
    output var logic irq,
    output var logic watchdog_running
);
    import wtc_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [2:0] low_power_rc_oscillator_sync_reg, low_power_rc_oscillator_sync_next;
    logic cfg_loaded_reg, cfg_loaded_next;
    wtc_ps_type run_ps_reg, run_ps_next;
    wtc_ps_type sleep_ps_reg, sleep_ps_next;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [3:0] status_reg, status_next;
    logic [3:0] mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic reset_req_reg, reset_req_next;
    logic wake_reg, wake_next;
    logic running_reg, running_next;
    logic aw_held_reg, aw_held_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    wtc_resp_type bresp_reg, bresp_next;
    wtc_rd_state_type rd_state_reg, rd_state_next;
    logic arready_reg, arready_next;
    logic [31:0] rdata_reg, rdata_next;
    wtc_resp_type rresp_reg, rresp_next;

    // ****************************************
    // Combinational helpers
    // ****************************************
    logic aw_have;
    logic w_have;
    logic do_write;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] lane_mask;
    logic [31:0] ctrl_wr;
    logic key_ok;
    logic bad_key;
    logic fault;
    logic en_eff;
    logic sleeping;
    logic low_power_rc_oscillator_tick;
    wtc_ps_type ps_sel;
    logic expire;
    logic window_open;
    logic [31:0] count;
    logic [3:0] events;
    logic [3:0] w1c;
    logic [31:0] ctrl_view;

    // ****************************************
    // Byte lanes to bit mask
    // ****************************************
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign lane_mask[lane*8 +: 8] = {8{wr_strb[lane]}};
        end
    endgenerate

    // ****************************************
    // Watchdog core
    // ****************************************
    // Fuse forces the watchdog on; software bit only matters without it
    assign en_eff = fuse_watchdog_enable | ctrl_reg[`WTC_ON_BIT];
    assign sleeping = sleep_mode | idle_mode;
    assign ps_sel = sleep_mode ? sleep_ps_reg : run_ps_reg;
    // Rising oscillator edge seen after the two-stage synchroniser
    assign low_power_rc_oscillator_tick = low_power_rc_oscillator_sync_reg[1] & ~low_power_rc_oscillator_sync_reg[2];

    wtc_tick_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .tick(low_power_rc_oscillator_tick),
        .run(en_eff),
        .clear(key_ok),
        .postscale(ps_sel),
        .expire(expire),
        .window_open(window_open),
        .count(count)
    );

    // Reserved bits never reach the stored control value
    assign ctrl_wr = wr_data & lane_mask & `WTC_CTRL_WMASK;
    assign ctrl_view = {16'h0, ctrl_reg[`WTC_ON_BIT], 2'h0, run_ps_reg,
                        2'h0, sleep_ps_reg, ctrl_reg[`WTC_WINEN_BIT]};

    // ****************************************
    // Write channel and register effects
    // ****************************************
    always_comb begin
        aw_have = aw_held_reg | (s_axi_awvalid & awready_reg);
        w_have = w_held_reg | (s_axi_wvalid & wready_reg);
        wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
        wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
        wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
        do_write = aw_have & w_have;
        aw_held_next = aw_held_reg;
        awaddr_next = awaddr_reg;
        w_held_next = w_held_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        w1c = 4'h0;
        key_ok = 1'b0;
        bad_key = 1'b0;
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `WTC_RESP_OKAY;
            if (wr_addr == `WTC_CTRL_OFF) begin
                ctrl_next = (ctrl_reg & ~(lane_mask & `WTC_CTRL_WMASK))
                            | ctrl_wr;
                // Key must arrive alone on the upper halfword lanes
                if (wr_strb == `WTC_KEY_STRB
                    && wr_data[31:16] == `WTC_KEY) begin
                    key_ok = 1'b1;
                end else if (wr_strb[3:2] != 2'h0) begin
                    bad_key = 1'b1;
                end
            end else if (wr_addr == `WTC_CTRL_CLR_OFF) begin
                ctrl_next = ctrl_reg & ~ctrl_wr;
            end else if (wr_addr == `WTC_CTRL_SET_OFF) begin
                ctrl_next = ctrl_reg | ctrl_wr;
            end else if (wr_addr == `WTC_CTRL_INV_OFF) begin
                ctrl_next = ctrl_reg ^ ctrl_wr;
            end else if (wr_addr == `WTC_STAT_OFF) begin
                w1c = wr_data[3:0] & {4{wr_strb[0]}};
            end else if (wr_addr == `WTC_MASK_OFF) begin
                if (wr_strb[0]) begin
                    mask_next = wr_data[3:0];
                end
            end else if (wr_addr != `WTC_COUNT_OFF) begin
                bresp_next = `WTC_RESP_SLVERR;
            end
        end
        awready_next = ~aw_held_next & ~bvalid_next;
        wready_next = ~w_held_next & ~bvalid_next;
    end

    // ****************************************
    // Events, reset and wake requests
    // ****************************************
    always_comb begin
        // Early clear in windowed mode is treated as a runaway program
        fault = key_ok & en_eff & ctrl_reg[`WTC_WINEN_BIT]
                & ~window_open;
        reset_req_next = (expire & ~sleeping) | fault;
        wake_next = expire & sleeping;
        running_next = en_eff;
        events = 4'h0;
        events[`WTC_EV_EXPIRE] = expire;
        events[`WTC_EV_FAULT] = fault;
        events[`WTC_EV_WAKE] = wake_next;
        events[`WTC_EV_BADKEY] = bad_key;
        // A new event beats a clear in the same cycle
        status_next = (status_reg & ~w1c) | events;
        irq_next = |(status_next & mask_next);
        low_power_rc_oscillator_sync_next = {low_power_rc_oscillator_sync_reg[1:0], low_power_rc_oscillator_clk_pin};
        cfg_loaded_next = 1'b1;
        run_ps_next = run_ps_reg;
        sleep_ps_next = sleep_ps_reg;
        // Configuration is caught once, after reset release
        if (!cfg_loaded_reg) begin
            run_ps_next = cfg_run_postscale;
            sleep_ps_next = cfg_sleep_postscale;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    always_comb begin
        rd_state_next = rd_state_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        case (rd_state_reg)
            WTC_RD_IDLE: begin
                // Ready is still low on the first edge after reset
                if (s_axi_arvalid && arready_reg) begin
                    rd_state_next = WTC_RD_DATA;
                    rresp_next = `WTC_RESP_OKAY;
                    rdata_next = 32'h0;
                    if (s_axi_araddr == `WTC_CTRL_OFF) begin
                        rdata_next = ctrl_view;
                    end else if (s_axi_araddr == `WTC_CTRL_CLR_OFF
                                 || s_axi_araddr == `WTC_CTRL_SET_OFF
                                 || s_axi_araddr == `WTC_CTRL_INV_OFF) begin
                        rdata_next = ctrl_view;
                    end else if (s_axi_araddr == `WTC_STAT_OFF) begin
                        rdata_next = {28'h0, status_reg};
                    end else if (s_axi_araddr == `WTC_MASK_OFF) begin
                        rdata_next = {28'h0, mask_reg};
                    end else if (s_axi_araddr == `WTC_COUNT_OFF) begin
                        rdata_next = count;
                    end else begin
                        rresp_next = `WTC_RESP_SLVERR;
                    end
                end
            end
            WTC_RD_DATA: begin
                if (s_axi_rready) begin
                    rd_state_next = WTC_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = WTC_RD_IDLE;
            end
        endcase
        arready_next = (rd_state_next == WTC_RD_IDLE);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_power_rc_oscillator_sync_reg <= 3'h0;
            cfg_loaded_reg <= 1'b0;
            run_ps_reg <= 5'h00;
            sleep_ps_reg <= 5'h00;
            ctrl_reg <= `WTC_CTRL_RESET;
            status_reg <= `WTC_EV_RESET;
            mask_reg <= `WTC_EV_RESET;
            irq_reg <= 1'b0;
            reset_req_reg <= 1'b0;
            wake_reg <= 1'b0;
            running_reg <= 1'b0;
            aw_held_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `WTC_RESP_OKAY;
            rd_state_reg <= WTC_RD_IDLE;
            arready_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `WTC_RESP_OKAY;
        end else if (clk_en) begin
            low_power_rc_oscillator_sync_reg <= low_power_rc_oscillator_sync_next;
            cfg_loaded_reg <= cfg_loaded_next;
            run_ps_reg <= run_ps_next;
            sleep_ps_reg <= sleep_ps_next;
            ctrl_reg <= ctrl_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
            reset_req_reg <= reset_req_next;
            wake_reg <= wake_next;
            running_reg <= running_next;
            aw_held_reg <= aw_held_next;
            awaddr_reg <= awaddr_next;
            w_held_reg <= w_held_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rd_state_reg <= rd_state_next;
            arready_reg <= arready_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = (rd_state_reg == WTC_RD_DATA);
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign device_reset_req = reset_req_reg;
    assign wake_req = wake_reg;
    assign irq = irq_reg;
    assign watchdog_running = running_reg;
endmodule // wtc_watchdog_timer_control

`default_nettype wire

// *** verif/wtc_watchdog_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********
// Checker
// ********
module wtc_watchdog_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fuse_watchdog_enable,
    input wire wtc_pkg::wtc_ps_type cfg_run_postscale,
    input wire wtc_pkg::wtc_ps_type cfg_sleep_postscale,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire wtc_pkg::wtc_resp_type s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic device_reset_req,
    input wire logic wake_req,
    input wire logic watchdog_running
);
    import wtc_pkg::*;
    logic [11:0] ra_reg;
    logic ctl;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read address is gone by the data beat, so keep it
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            ra_reg <= s_axi_araddr;
        end
    end
    assign ctl = (ra_reg[11:4] == 8'hc0);
    AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write answer late");
    AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    AST_W_READY_BACK: assert property ($fell(s_axi_bvalid)
        |-> s_axi_awready && s_axi_wready) else $error("write ready late");
    AST_R_READY_BACK: assert property ($fell(s_axi_rvalid) |-> s_axi_arready)
        else $error("read ready late");
    AST_RSVD_ZERO: assert property (
        s_axi_rvalid && ctl |-> s_axi_rdata[31:16] == 16'h0000 &&
        s_axi_rdata[14:13] == 2'h0 && s_axi_rdata[7:6] == 2'h0)
        else $error("reserved bits set");
    AST_RUN_PS: assert property (
        s_axi_rvalid && ctl |-> s_axi_rdata[12:8] == cfg_run_postscale)
        else $error("run postscale wrong");
    AST_SLEEP_PS: assert property (
        s_axi_rvalid && ctl |-> s_axi_rdata[5:1] == cfg_sleep_postscale)
        else $error("sleep postscale wrong");
    AST_FUSE_RUN: assert property (
        fuse_watchdog_enable |=> watchdog_running) else $error("fuse ignored");
    AST_RST_PULSE: assert property (
        device_reset_req |=> !device_reset_req) else $error("reset too long");
    AST_WAKE_ASLEEP: assert property (
        wake_req |-> !device_reset_req && $past(sleep_mode || idle_mode))
        else $error("wake while awake");
endmodule // wtc_watchdog_sva
`default_nettype wire

// *** verif/test_watchdog_timer_control.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_timer_control;
    import wtc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, low_power_rc_oscillator_clk_pin = 1'b0;
    logic fuse_watchdog_enable = 1'b0, sleep_mode = 1'b0, idle_mode = 1'b0;
    wtc_ps_type cfg_run_postscale = 5'h03, cfg_sleep_postscale = 5'h02;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, device_reset_req, wake_req, irq, watchdog_running;
    wtc_resp_type s_axi_bresp, s_axi_rresp, resp;
    int err_total = 0, checked = 0, n_rst = 0, n_wake = 0;
    logic [11:0] al_a [4] = '{12'hc04, 12'hc08, 12'hc0c, 12'hc0c};
    logic [31:0] al_d [4] = '{32'h1, 32'h8001, 32'h8001, 32'h1};
    logic [1:0] al_e [4] = '{2'b10, 2'b11, 2'b00, 2'b01};

    wtc_watchdog_timer_control i_dut (.aclk, .aresetn, .clk_en, .low_power_rc_oscillator_clk_pin,
        .fuse_watchdog_enable, .cfg_run_postscale, .cfg_sleep_postscale,
        .sleep_mode, .idle_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .device_reset_req, .wake_req, .irq, .watchdog_running);

    initial begin
        forever #5 aclk = ~aclk;
    end
    // Pulses last one cycle, so count them as they pass
    always @(posedge aclk) begin
        if (device_reset_req === 1'b1) n_rst++;
        if (wake_req === 1'b1) n_wake++;
    end
    // ********
    // Tasks
    // ********
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_resp(input wtc_resp_type got, input wtc_resp_type exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 100);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (t >= 100) err_total++;
    endtask
    task rd(input logic [11:0] a);
        int t;
        t = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 100);
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (t >= 100) err_total++;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        chk(rdv, e);
        chk_resp(resp, 2'h0);
    endtask
    task key;
        wr(12'hc00, 32'h5743_0000, 4'hc);
    endtask
    // One oscillator period is eight bus clocks, ample for the synchroniser
    task tick(input int n);
        repeat (n) begin
            @(posedge aclk);
            low_power_rc_oscillator_clk_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            low_power_rc_oscillator_clk_pin <= 1'b0;
            repeat (3) @(posedge aclk);
        end
    endtask
    task settle;
        repeat (3) @(posedge aclk);
    endtask
    function automatic logic [31:0] cv(input logic on, input logic win);
        return {16'h0000, on, 2'b00, cfg_run_postscale, 2'b00,
            cfg_sleep_postscale, win};
    endfunction
    task reset_dut;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task results;
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        results;
    end
    // ********
    // Tests
    // ********
    initial begin
        reset_dut;
        rdc(12'hc00, cv(0, 0));
        wr(12'hc00, 32'hffff_ffff, 4'h3);
        rdc(12'hc00, cv(1, 1));
        for (int i = 0; i < 4; i++) begin
            wr(al_a[i], al_d[i], 4'h3);
            rdc(12'hc00, cv(al_e[i][1], al_e[i][0]));
        end
        wr(12'hf00, 32'h0, 4'hf);
        chk_resp(resp, 2'h2);
        rd(12'hf00);
        chk(rdv, 32'h0);
        chk_resp(resp, 2'h2);
        fuse_watchdog_enable <= 1'b1;
        settle;
        chk(32'(watchdog_running), 32'h1);
        fuse_watchdog_enable <= 1'b0;
        wr(12'hc04, 32'h1, 4'h3);
        wr(12'hc08, 32'h8000, 4'h3);
        settle;
        chk(32'(watchdog_running), 32'h1);
        key;
        rdc(12'hc18, 32'h0);
        tick(3);
        rdc(12'hc18, 32'h3);
        clk_en <= 1'b0;
        tick(2);
        clk_en <= 1'b1;
        rdc(12'hc18, 32'h3);
        tick(4);
        chk(n_rst, 0);
        tick(1);
        chk(n_rst, 1);
        key;
        tick(6);
        key;
        tick(6);
        chk(n_rst, 1);
        wr(12'hc00, 32'h5744_0000, 4'hc);
        wr(12'hc00, 32'h5743_8000, 4'hf);
        tick(2);
        chk(n_rst, 2);
        rdc(12'hc10, 32'h9);
        wr(12'hc14, 32'h8, 4'h1);
        settle;
        chk(32'(irq), 32'h1);
        wr(12'hc10, 32'h8, 4'h1);
        settle;
        chk(32'(irq), 32'h0);
        rdc(12'hc10, 32'h1);
        key;
        wr(12'hc08, 32'h1, 4'h3);
        tick(6);
        key;
        settle;
        chk(n_rst, 2);
        key;
        settle;
        chk(n_rst, 3);
        wr(12'hc04, 32'h1, 4'h3);
        sleep_mode <= 1'b1;
        key;
        tick(3);
        chk(n_wake, 0);
        tick(1);
        chk(n_wake, 1);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        key;
        tick(8);
        chk(n_wake, 2);
        chk(n_rst, 3);
        rdc(12'hc10, 32'h7);
        idle_mode <= 1'b0;
        wr(12'hc04, 32'h8000, 4'h3);
        tick(10);
        chk(n_rst, 3);
        cfg_run_postscale <= 5'h11;
        cfg_sleep_postscale <= 5'h0e;
        reset_dut;
        rdc(12'hc00, cv(0, 0));
        results;
    end
endmodule // test_watchdog_timer_control

bind wtc_watchdog_timer_control wtc_watchdog_sva i_sva (.aclk, .aresetn,
    .fuse_watchdog_enable, .cfg_run_postscale, .cfg_sleep_postscale,
    .sleep_mode, .idle_mode, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .device_reset_req, .wake_req, .watchdog_running);
`default_nettype wire
